// [core/pew_host.sv]
// host controller that drives the parallel eeprom pins: reads, page writes, polling
`timescale 1ns/1ns

//////////////////////////////////////////////////////////////////////////////
module pew_host
(
    // clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          reset,
    // user command port
    input  wire logic                          req_valid,
    input  pew_pkg::pew_req_s                  req,
    output logic                               req_ready,
    output logic                               rsp_valid,
    output logic [pew_pkg::DATA_W-1:0]         rsp_data,
    output logic                               prog_busy,
    output logic                               page_error,
    // memory pins
    output pew_pkg::pew_pins_s                 pins,
    output logic [pew_pkg::DATA_W-1:0]         data_out,
    output logic                               data_oe_n,
    input  wire logic [pew_pkg::DATA_W-1:0]    data_in
);

    typedef enum logic [3:0] {
        ST_IDLE, ST_RD_ACCESS, ST_RD_DONE, ST_WR_SETUP, ST_WR_PULSE,
        ST_WR_HOLD, ST_PAGE_OPEN, ST_PROG_WAIT, ST_POLL_ACCESS, ST_POLL_GAP
    } pew_state_e;

    pew_state_e                       state;
    pew_state_e                       next_state;
    logic [7:0]                       phase;
    logic [pew_pkg::ADDR_W-1:0]       page_addr;
    logic [pew_pkg::DATA_W-1:0]       last_byte;
    logic [4:0]                       load_count;
    logic                             is_last_sent;
    logic                             poll_hit;
    logic                             load_running;
    logic                             load_expired;
    logic                             wdog_running;
    logic                             wdog_expired;
    logic                             gap_load;
    logic                             gap_running;

    //////////////////////////////////////////////////////////////////////////
    // decode
    wire is_read     = req.kind == pew_pkg::PEW_CMD_READ;
    wire is_last     = req.kind == pew_pkg::PEW_CMD_WRITE_LAST;
    wire same_page   = req.addr[pew_pkg::ADDR_W-1:pew_pkg::PAGE_LO_W]
                     == page_addr[pew_pkg::ADDR_W-1:pew_pkg::PAGE_LO_W];
    wire page_full   = load_count == 5'(pew_pkg::PAGE_MAX);
    wire phase_done_s = phase == 8'(pew_pkg::STROBE_CYC - 1);
    // one spare access cycle: data is sampled after the access time, not on its edge
    wire phase_done_a = phase == 8'(pew_pkg::ACCESS_CYC);
    wire poll_match  = data_in[7] == last_byte[7];
    wire accept      = req_valid && req_ready;
    wire start_write = accept && !is_read;
    wire fall_now    = state == ST_WR_SETUP;

    // earliest next falling strobe: byte load minimum counted in phase-free way
    logic [pew_pkg::TIMER_W-1:0] since_cnt;
    wire t_count_left_ok = since_cnt >= 17'(pew_pkg::LOAD_MIN_CYC);

    // byte load window; page is sealed this many cycles after the last fall
    pew_timer u_load_window
    (
        .clk_sys (clk_sys),
        .reset   (reset),
        .load    (fall_now),
        .count   (17'(pew_pkg::LOAD_MAX_CYC)),
        .running (load_running),
        .expired (load_expired)
    );

    // programming watchdog: stop polling after the longest program time
    pew_timer u_prog_wdog
    (
        .clk_sys (clk_sys),
        .reset   (reset),
        .load    (load_expired),
        .count   (17'(pew_pkg::PROGRAM_CYC)),
        .running (wdog_running),
        .expired (wdog_expired)
    );

    // spacing between polling reads
    assign gap_load = state == ST_POLL_ACCESS && phase_done_a;

    pew_timer u_poll_gap
    (
        .clk_sys (clk_sys),
        .reset   (reset),
        .load    (gap_load),
        .count   (17'(pew_pkg::POLL_GAP_CYC)),
        .running (gap_running),
        .expired ()
    );

    //////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_IDLE:
                if (accept)
                    next_state = is_read ? ST_RD_ACCESS : ST_WR_SETUP;
            ST_RD_ACCESS:
                if (phase_done_a)
                    next_state = ST_RD_DONE;
            ST_RD_DONE:
                next_state = ST_IDLE;
            ST_WR_SETUP:
                next_state = ST_WR_PULSE;
            ST_WR_PULSE:
                if (phase_done_s)
                    next_state = ST_WR_HOLD;
            ST_WR_HOLD:
                next_state = ST_PAGE_OPEN;
            ST_PAGE_OPEN:
                if (load_expired)
                    next_state = ST_PROG_WAIT;
                else if (accept)
                    next_state = ST_WR_SETUP;
            ST_PROG_WAIT:
                if (!gap_running)
                    next_state = ST_POLL_ACCESS;
            ST_POLL_ACCESS:
                if (phase_done_a)
                    next_state = ST_POLL_GAP;
            ST_POLL_GAP:
                if (poll_hit || wdog_expired || !wdog_running)
                    next_state = ST_IDLE;
                else
                    next_state = ST_PROG_WAIT;
            default:
                next_state = ST_IDLE;
        endcase
    end

    // commands are taken in idle, or inside an open page while room and time allow
    // host keeps page bits
    assign req_ready = (state == ST_IDLE)
                    || (state == ST_PAGE_OPEN && !is_read && same_page && !page_full
                        && t_count_left_ok && load_running && !load_expired && !is_last_sent);

    //////////////////////////////////////////////////////////////////////////
    // sequencing registers
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state <= ST_IDLE;
            phase <= 8'h00;
        end
        else
        begin
            state <= next_state;
            phase <= (next_state == state) ? phase + 8'h01 : 8'h00;
        end
    end

    // time since the last falling strobe; starts saturated so a first strobe is never too close
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            since_cnt <= 17'h1_FFFF;
        else if (fall_now)
            since_cnt <= '0;
        else if (since_cnt != 17'h1_FFFF)
            since_cnt <= since_cnt + 17'h0_0001;
    end

    // page bookkeeping
    // page length count
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            page_addr    <= '0;
            last_byte    <= '0;
            load_count   <= 5'h00;
            is_last_sent <= 1'b0;
            page_error   <= 1'b0;
        end
        else if (start_write)
        begin
            page_addr    <= req.addr;
            last_byte    <= req.data;
            load_count   <= (state == ST_IDLE) ? 5'h01 : load_count + 5'h01;
            is_last_sent <= is_last;
            page_error   <= 1'b0;
        end
        else if (state == ST_PAGE_OPEN && req_valid && !is_read && !same_page)
            page_error   <= 1'b1;
        else if (state == ST_IDLE)
            is_last_sent <= 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////
    // pin drive, all registered
    // strobe only with oe high
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            pins.chip_select_n   <= pew_pkg::STROBE_IDLE;
            pins.output_enable_n <= pew_pkg::STROBE_IDLE;
            pins.write_strobe_n  <= pew_pkg::STROBE_IDLE;
            pins.address_lines   <= '0;
            data_out             <= '0;
            data_oe_n            <= 1'b1;
        end
        else
        begin
            pins.chip_select_n   <= !(next_state inside {ST_RD_ACCESS, ST_WR_SETUP,
                                    ST_WR_PULSE, ST_WR_HOLD, ST_POLL_ACCESS});
            pins.output_enable_n <= !(next_state inside {ST_RD_ACCESS, ST_POLL_ACCESS});
            pins.write_strobe_n  <= next_state != ST_WR_PULSE;
            if (accept)
                pins.address_lines <= req.addr;
            else if (next_state == ST_POLL_ACCESS)
                pins.address_lines <= page_addr;
            if (accept && !is_read)
                data_out <= req.data;
            data_oe_n <= !(next_state inside {ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD});
        end
    end

    // answers and busy flag; data taken while select and enable are still low
    // poll on true bit 7
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            rsp_valid <= 1'b0;
            rsp_data  <= '0;
            prog_busy <= 1'b0;
            poll_hit  <= 1'b0;
        end
        else
        begin
            rsp_valid <= state == ST_RD_DONE;
            if (state == ST_RD_ACCESS && phase_done_a)
                rsp_data <= data_in;
            if (state == ST_POLL_ACCESS && phase_done_a)
                poll_hit <= poll_match;
            prog_busy <= next_state inside {ST_PROG_WAIT, ST_POLL_ACCESS, ST_POLL_GAP};
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // checks
    strobe_oe_excl_a: assert property (@(posedge clk_sys) disable iff (reset)
        !pins.write_strobe_n |-> pins.output_enable_n && !pins.chip_select_n)
        else $error("write strobe with output enable low");
    strobe_width_a: assert property (@(posedge clk_sys) disable iff (reset)
        $fell(pins.write_strobe_n) |-> !pins.write_strobe_n [*2])
        else $error("write strobe too short");
    // the counter before the fall holds the gap to the previous fall, less one
    load_spacing_a: assert property (@(posedge clk_sys) disable iff (reset)
        $fell(pins.write_strobe_n) |-> $past(since_cnt) >= 17'(pew_pkg::LOAD_MIN_CYC - 1))
        else $error("byte loads too close");
    page_bits_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_PAGE_OPEN && accept) |-> same_page)
        else $error("page address changed");
    read_float_a: assert property (@(posedge clk_sys) disable iff (reset)
        !pins.output_enable_n |-> data_oe_n)
        else $error("host drives bus during read");
    page_limit_a: assert property (@(posedge clk_sys) disable iff (reset)
        load_count <= 5'(pew_pkg::PAGE_MAX))
        else $error("page too long");
    page_close_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_PAGE_OPEN && load_expired) |=> prog_busy)
        else $error("page did not close");
    prog_no_write_a: assert property (@(posedge clk_sys) disable iff (reset)
        prog_busy |-> pins.write_strobe_n && !req_ready)
        else $error("write while programming");

endmodule

// [core/pew_pkg.sv]
// package: pin timing, counts and carriers for the parallel eeprom host controller
package pew_pkg;

    // clock figures
    localparam int CLK_PERIOD_NS      = 100;

    // pin timing, as printed
    localparam int STROBE_WIDTH_NS    = 150;
    localparam int READ_ACCESS_NS     = 300;
    localparam int BYTE_LOAD_MIN_US   = 3;
    localparam int BYTE_LOAD_MAX_US   = 20;
    localparam int PROGRAM_MAX_MS     = 10;
    localparam int POLL_GAP_US        = 10;

    // cycle counts; least times round up, longest times round down
    localparam int STROBE_CYC    = (STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_CYC    = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOAD_MIN_CYC  = (BYTE_LOAD_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOAD_MAX_CYC  = (BYTE_LOAD_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam int POLL_GAP_CYC  = (POLL_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROGRAM_CYC   = (PROGRAM_MAX_MS * 1000000) / CLK_PERIOD_NS;

    // sizes
    localparam int ADDR_W        = 11;
    localparam int DATA_W        = 8;
    localparam int PAGE_LO_W     = 4;
    localparam int TIMER_W       = 17;
    localparam int PAGE_MAX      = 16;

    // pin levels after reset
    localparam logic STROBE_IDLE = 1'b1;

    // host command kinds
    typedef enum logic [1:0] {
        PEW_CMD_READ,
        PEW_CMD_WRITE,
        PEW_CMD_WRITE_LAST
    } pew_cmd_e;

    // one command from the user side
    typedef struct packed {
        pew_cmd_e            kind;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } pew_req_s;

    // pins toward the memory
    typedef struct packed {
        logic                chip_select_n;
        logic                output_enable_n;
        logic                write_strobe_n;
        logic [ADDR_W-1:0]   address_lines;
    } pew_pins_s;

endpackage

// [core/pew_timer.sv]
// down counter with a one-cycle expiry flag
`timescale 1ns/1ns

module pew_timer
(
    // clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          reset,
    // control
    input  wire logic                          load,
    input  wire logic [pew_pkg::TIMER_W-1:0]   count,
    // status
    output logic                               running,
    output logic                               expired
);

    logic [pew_pkg::TIMER_W-1:0] remain;
    wire                         last_tick = running && (remain == 17'h0_0001);

    // load wins over expiry so a reload never loses a window
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            remain <= '0;
        else if (load)
            remain <= count;
        else if (running)
            remain <= remain - 17'h0_0001;
    end

    assign running = (remain != '0);
    assign expired = last_tick && !load;

endmodule

// [tb/pew_mem_model.sv]
// behavioural model of the byte-wide eeprom as seen from its pins
`timescale 1ns/1ns

module pew_mem_model
(
    // pins from the host
    input  wire pew_pkg::pew_pins_s   pins,
    input  wire logic [7:0]           bus_in,
    // programming time in microseconds, so one bench can try quick and slow parts
    input  wire logic [15:0]          prog_us,
    // read drive toward the bus
    output logic [7:0]                drive,
    output logic                      drive_en
);
    logic [7:0]  mem [0:2047];
    logic [7:0]  pend [0:15];
    logic [15:0] pmask = '0;
    logic [10:0] wa = '0;
    logic [10:0] last_a = '0;
    logic [7:0]  last_d = '0;
    logic        busy = 1'b0;
    logic        rd_late = 1'b0;
    logic        rd;
    logic        wr;
    int          loads = 0;
    int          programs = 0;
    int          faults = 0;
    time         t_fall = 0;

    // mode from select, enable and strobe
    assign rd = !pins.chip_select_n && !pins.output_enable_n && pins.write_strobe_n;
    assign wr = !pins.chip_select_n && !pins.write_strobe_n && pins.output_enable_n;
    // data is junk until the access time has passed
    always @(rd) rd_late <= #300 rd;
    // only polls of the last byte answer while busy
    assign drive_en = rd && rd_late && (!busy || pins.address_lines == last_a);
    assign drive = busy ? {~last_d[7], last_d[6:0]} : mem[pins.address_lines];

    // address taken as the later of select or strobe falls
    always @(posedge wr)
        if (!busy)
        begin
            if (loads != 0 && (($time - t_fall) < 3000 || pins.address_lines[10:4] != wa[10:4]))
                faults++;
            wa = pins.address_lines;
            t_fall = $time;
        end

    // byte taken as the first one rises; glitches are dropped
    always @(negedge wr)
        if (!busy && ($time - t_fall) >= 20)
        begin
            pend[wa[3:0]] = bus_in;
            pmask[wa[3:0]] = 1'b1;
            last_a = wa;
            last_d = bus_in;
            loads++;
        end

    // page closes after 20 us without a falling strobe, then programs alone
    always
    begin
        wait (loads != 0);
        #100;
        if (($time - t_fall) > 20000)
        begin
            busy = 1'b1;
            programs++;
            #(prog_us * 1000);
            for (int i = 0; i < 16; i++)
                if (pmask[i])
                    mem[{last_a[10:4], i[3:0]}] = pend[i];
            pmask = '0;
            loads = 0;
            busy = 1'b0;
        end
    end
endmodule

// [tb/parallel_eeprom_page_write_test.sv]
// self-checking bench for the parallel eeprom host controller
`timescale 1ns/1ns

module parallel_eeprom_page_write_test;
    logic               clk_sys = 1'b0;
    logic               reset = 1'b1;
    logic               req_valid = 1'b0;
    pew_pkg::pew_req_s  req = '0;
    logic               req_ready;
    logic               rsp_valid;
    logic [7:0]         rsp_data;
    logic               prog_busy;
    logic               page_error;
    pew_pkg::pew_pins_s pins;
    logic [7:0]         data_out;
    logic               data_oe_n;
    logic [7:0]         bus;
    logic [7:0]         last_bus = 8'h00;
    logic [7:0]         m_drive;
    logic               m_en;
    logic [15:0]        prog_us = 16'h012c;
    int                 n_fail = 0;
    int                 compares = 0;

    pew_host i_dut (.clk_sys(clk_sys), .reset(reset), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .prog_busy(prog_busy), .page_error(page_error), .pins(pins),
        .data_out(data_out), .data_oe_n(data_oe_n), .data_in(bus));
    pew_mem_model i_mem (.pins(pins), .bus_in(bus), .prog_us(prog_us), .drive(m_drive),
        .drive_en(m_en));

    // wire level; an undriven bus toggles so stale data never looks valid
    assign bus = !data_oe_n ? data_out : m_en ? m_drive : ~last_bus;
    always @(posedge clk_sys) last_bus <= bus;
    initial forever #50 clk_sys = ~clk_sys;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // enable stays high while the host strobes or drives the bus
    always @(posedge clk_sys)
        if (!reset && (!data_oe_n || !pins.write_strobe_n))
            check(pins.output_enable_n, 1'b1);

    // bounded wait for a level, sampled just after each edge
    task automatic wait_lvl(ref logic s, input logic v, input int lim);
        int n;
        n = 0;
        while (s !== v && n < lim)
        begin
            @(posedge clk_sys);
            #10;
            n++;
        end
        if (n >= lim)
        begin
            n_fail++;
            wrap_up();
        end
    endtask

    task automatic offer(input pew_pkg::pew_cmd_e k, input logic [10:0] a,
                         input logic [7:0] d);
        @(posedge clk_sys);
        #10;
        req_valid = 1'b1;
        req = {k, a, d};
    endtask

    task automatic take();
        wait_lvl(req_ready, 1'b1, 60000);
        @(posedge clk_sys);
        #10;
        req_valid = 1'b0;
    endtask

    task automatic wr(input pew_pkg::pew_cmd_e k, input logic [10:0] a, input logic [7:0] d);
        offer(k, a, d);
        take();
    endtask

    task automatic rd(input logic [10:0] a, input logic [7:0] exp);
        offer(pew_pkg::PEW_CMD_READ, a, 8'h00);
        take();
        wait_lvl(rsp_valid, 1'b1, 20);
        check(rsp_data, exp);
    endtask

    task automatic wait_done(input int total);
        wait_lvl(prog_busy, 1'b1, 600);
        wait_lvl(prog_busy, 1'b0, 30000);
        check(i_mem.busy, 1'b0);
        check(i_mem.programs, total);
    endtask

    task automatic t_reset();
        check({pins.chip_select_n, pins.output_enable_n, pins.write_strobe_n, data_oe_n},
              4'hf);
        check({prog_busy, rsp_valid, req_ready}, 3'h1);
    endtask

    // slow part, top address, bit 7 set so polling sees it inverted
    task automatic t_single();
        prog_us = 16'h07d0;
        wr(pew_pkg::PEW_CMD_WRITE_LAST, 11'h7ff, 8'h80);
        wait_done(1);
        check(i_mem.mem[11'h7ff], 8'h80);
        rd(11'h7ff, 8'h80);
    endtask

    // full sixteen-byte page must program once
    task automatic t_page();
        prog_us = 16'h012c;
        for (int i = 0; i < 16; i++)
            wr(i == 15 ? pew_pkg::PEW_CMD_WRITE_LAST : pew_pkg::PEW_CMD_WRITE,
               {7'h35, i[3:0]}, 8'h40 + 8'(i));
        wait_done(2);
        for (int i = 0; i < 16; i++)
            rd({7'h35, i[3:0]}, 8'h40 + 8'(i));
        check(i_mem.faults, 0);
    endtask

    // a write to another page while one is open must wait for a new page
    task automatic t_page_err();
        wr(pew_pkg::PEW_CMD_WRITE, 11'h015, 8'h5a);
        offer(pew_pkg::PEW_CMD_WRITE, 11'h025, 8'hc3);
        wait_lvl(page_error, 1'b1, 40);
        check(page_error, 1'b1);
        take();
        wait_done(4);
        rd(11'h015, 8'h5a);
        rd(11'h025, 8'hc3);
        check(i_mem.faults, 0);
    endtask

    initial
    begin
        repeat (4) @(posedge clk_sys);
        t_reset();
        #10;
        reset = 1'b0;
        t_single();
        t_page();
        t_page_err();
        wrap_up();
    end
endmodule
